/* src/wake_offload_pkg.sv */
package wake_offload_pkg;

    localparam logic [11:0] OFFSET_CTRL       = 12'h600;
    localparam logic [11:0] OFFSET_ENTRY0     = 12'h610;
    localparam logic [11:0] OFFSET_ENTRY1     = 12'h650;
    localparam logic [11:0] OFFSET_RESUME_CFG = 12'h6f0;

    localparam int BIT_BYPASS     = 31;
    localparam int BIT_FWD_ADDR   = 10;
    localparam int BIT_FWD_SOL    = 9;
    localparam int BIT_ADV_SEL    = 8;
    localparam int BIT_SOL_SEEN   = 7;
    localparam int BIT_ADDR_SEEN  = 6;
    localparam int BIT_V6_SEEN    = 5;
    localparam int BIT_V4_SEEN    = 4;
    localparam int BIT_SOL_EN     = 3;
    localparam int BIT_ADDR_EN    = 2;
    localparam int BIT_V6_WAKE    = 1;
    localparam int BIT_V4_WAKE    = 0;
    localparam int BIT_RES_FLAGS  = 0;
    localparam int BIT_RES_ENABLE = 1;

    localparam logic [31:0] CTRL_WRITABLE_MASK = 32'h8000070f;
    localparam logic [31:0] CTRL_RESET         = 32'h00000000;
    localparam logic [31:0] ENTRY_RESET        = 32'h00000000;

    localparam logic [103:0] SOLICITED_PREFIX = 104'hff0200000000000000000001ff;

    typedef enum logic [1:0] {
        FRAME_NONE = 2'h0,
        FRAME_ADDR = 2'h1,
        FRAME_SOL  = 2'h2,
        FRAME_SYN  = 2'h3
    } frame_kind_e;

    typedef struct packed {
        logic        done;
        frame_kind_e kind;
        logic        is_v6;
        logic        fcs_ok;
        logic        ip_csum_ok;
        logic        l4_csum_ok;
        logic        for_us;
        logic        da_qualifies;
        logic [127:0] ip6_dest;
        logic [127:0] target_addr;
    } rx_frame_s;

endpackage

/* src/wake_offload_ctrl.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Bypass clear: all checksums and FCS required
// - Bypass set: only FCS checked
// - Bit 10 forwards or sinks address-resolution frames
// - Bit 9 forwards or sinks solicitation frames
// - Bit 8 picks advert source address
// - Bit 7 set on valid solicitation
// - Bit 6 set on valid address-resolution
// - Bit 5 set on IPv6 SYN
// - Bit 4 set on IPv4 SYN
// - Resume clears bits 5,4 when enabled
// - Bit 3 enables solicitation reply
// - Bit 2 enables address-resolution reply
// - Bit 1 lets IPv6 SYN wake
// - Bit 0 lets IPv4 SYN wake
// - Resume clears bits 1,0 when enabled
// - Entries used only with solicitation enabled
// - Compare full 128-bit header destination
// - Solicited-node: compare top 24 bits only
// - Entries: four words, least first
// - Word 3 top byte received first
module wake_offload_ctrl (
    // Clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        rstn_in,
    // Register port
    input  wire logic [11:0]                 reg_addr_in,
    input  wire logic [31:0]                 reg_wdata_in,
    input  wire logic                        reg_write_in,
    input  wire logic                        reg_read_in,
    output logic      [31:0]                 reg_rdata_out,
    // Parsed receive frame
    input  wire wake_offload_pkg::rx_frame_s frame_in,
    input  wire logic                        resume_done_in,
    // Decisions
    output logic                             forward_out,
    output logic                             sink_out,
    output logic                             solicit_reply_out,
    output logic                             addr_reply_out,
    output logic                             wake_out,
    output logic      [1:0]                  entry_match_out,
    output logic      [127:0]                advert_source_out
);

    logic [31:0]  ctrl_q;
    logic [31:0]  ctrl_d;
    logic [1:0]   resume_cfg_q;
    logic [1:0]   resume_cfg_d;
    logic [31:0]  entry_q [0:7];
    logic [31:0]  entry_d [0:7];
    logic [31:0]  rdata_d;
    logic         checks_ok;
    logic         solicited;
    logic [127:0] ent0;
    logic [127:0] ent1;
    logic [1:0]   match;
    logic         fwd_d;
    logic         sink_d;
    logic         sol_rep_d;
    logic         addr_rep_d;
    logic         wake_d;
    logic [1:0]   match_d;
    logic [127:0] adv_d;
    logic         set_sol;
    logic         set_addr;
    logic         set_v6;
    logic         set_v4;

    // Least significant word at the lowest offset
    assign ent0 = {entry_q[3], entry_q[2], entry_q[1], entry_q[0]};
    assign ent1 = {entry_q[7], entry_q[6], entry_q[5], entry_q[4]};

    always_comb begin
        if (ctrl_q[wake_offload_pkg::BIT_BYPASS]) begin
            checks_ok = frame_in.fcs_ok;
        end else begin
            checks_ok = frame_in.fcs_ok && frame_in.ip_csum_ok && frame_in.l4_csum_ok;
        end
    end

    assign solicited = (frame_in.ip6_dest[127:24] == wake_offload_pkg::SOLICITED_PREFIX);

    // Header address bit 127 is the first byte on the wire, so a plain compare matches wire order
    always_comb begin
        if (solicited) begin
            match[0] = (ent0[127:104] == frame_in.ip6_dest[23:0]);
            match[1] = (ent1[127:104] == frame_in.ip6_dest[23:0]);
        end else begin
            match[0] = (ent0 == frame_in.ip6_dest);
            match[1] = (ent1 == frame_in.ip6_dest);
        end
        if (!(ctrl_q[wake_offload_pkg::BIT_SOL_EN] && frame_in.da_qualifies && frame_in.is_v6)) begin
            match = 2'h0;
        end
    end

    always_comb begin
        set_sol  = 1'b0;
        set_addr = 1'b0;
        set_v6   = 1'b0;
        set_v4   = 1'b0;
        fwd_d    = 1'b0;
        sink_d   = 1'b0;
        sol_rep_d  = 1'b0;
        addr_rep_d = 1'b0;
        wake_d   = 1'b0;
        match_d  = 2'h0;
        adv_d    = advert_source_out;
        if (frame_in.done && checks_ok) begin
            case (frame_in.kind)
                wake_offload_pkg::FRAME_ADDR: begin
                    set_addr = 1'b1;
                    if (ctrl_q[wake_offload_pkg::BIT_ADDR_EN] && frame_in.for_us) begin
                        addr_rep_d = 1'b1;
                        fwd_d  = ctrl_q[wake_offload_pkg::BIT_FWD_ADDR];
                        sink_d = !ctrl_q[wake_offload_pkg::BIT_FWD_ADDR];
                    end
                end
                wake_offload_pkg::FRAME_SOL: begin
                    set_sol = 1'b1;
                    match_d = match;
                    if (ctrl_q[wake_offload_pkg::BIT_SOL_EN] && frame_in.for_us && (match != 2'h0)) begin
                        sol_rep_d = 1'b1;
                        fwd_d  = ctrl_q[wake_offload_pkg::BIT_FWD_SOL];
                        sink_d = !ctrl_q[wake_offload_pkg::BIT_FWD_SOL];
                        if (ctrl_q[wake_offload_pkg::BIT_ADV_SEL]) begin
                            adv_d = match[0] ? ent0 : ent1;
                        end else begin
                            adv_d = frame_in.target_addr;
                        end
                    end
                end
                wake_offload_pkg::FRAME_SYN: begin
                    if (frame_in.is_v6) begin
                        set_v6 = 1'b1;
                        wake_d = ctrl_q[wake_offload_pkg::BIT_V6_WAKE];
                    end else begin
                        set_v4 = 1'b1;
                        wake_d = ctrl_q[wake_offload_pkg::BIT_V4_WAKE];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        ctrl_d       = ctrl_q;
        resume_cfg_d = resume_cfg_q;
        for (int i = 0; i < 8; i++) begin
            entry_d[i] = entry_q[i];
        end
        if (reg_write_in) begin
            if (reg_addr_in == wake_offload_pkg::OFFSET_CTRL) begin
                ctrl_d = (ctrl_q & ~wake_offload_pkg::CTRL_WRITABLE_MASK)
                       | (reg_wdata_in & wake_offload_pkg::CTRL_WRITABLE_MASK);
                ctrl_d[7:4] = ctrl_q[7:4] & ~reg_wdata_in[7:4];
            end else if (reg_addr_in == wake_offload_pkg::OFFSET_RESUME_CFG) begin
                resume_cfg_d = reg_wdata_in[1:0];
            end else if (reg_addr_in[11:4] == wake_offload_pkg::OFFSET_ENTRY0[11:4]
                         && reg_addr_in[1:0] == 2'h0) begin
                entry_d[reg_addr_in[3:2]] = reg_wdata_in;
            end else if (reg_addr_in[11:4] == wake_offload_pkg::OFFSET_ENTRY1[11:4]
                         && reg_addr_in[1:0] == 2'h0) begin
                entry_d[{1'b1, reg_addr_in[3:2]}] = reg_wdata_in;
            end
        end
        if (resume_done_in && resume_cfg_q[wake_offload_pkg::BIT_RES_FLAGS]) begin
            ctrl_d[wake_offload_pkg::BIT_V6_SEEN] = 1'b0;
            ctrl_d[wake_offload_pkg::BIT_V4_SEEN] = 1'b0;
        end
        if (resume_done_in && resume_cfg_q[wake_offload_pkg::BIT_RES_ENABLE]) begin
            ctrl_d[wake_offload_pkg::BIT_V6_WAKE] = 1'b0;
            ctrl_d[wake_offload_pkg::BIT_V4_WAKE] = 1'b0;
        end
        // Hardware sets win over a clear in the same cycle
        if (set_sol) begin
            ctrl_d[wake_offload_pkg::BIT_SOL_SEEN] = 1'b1;
        end
        if (set_addr) begin
            ctrl_d[wake_offload_pkg::BIT_ADDR_SEEN] = 1'b1;
        end
        if (set_v6) begin
            ctrl_d[wake_offload_pkg::BIT_V6_SEEN] = 1'b1;
        end
        if (set_v4) begin
            ctrl_d[wake_offload_pkg::BIT_V4_SEEN] = 1'b1;
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_read_in) begin
            if (reg_addr_in == wake_offload_pkg::OFFSET_CTRL) begin
                rdata_d = ctrl_q;
            end else if (reg_addr_in == wake_offload_pkg::OFFSET_RESUME_CFG) begin
                rdata_d = {30'h00000000, resume_cfg_q};
            end else if (reg_addr_in[11:4] == wake_offload_pkg::OFFSET_ENTRY0[11:4]
                         && reg_addr_in[1:0] == 2'h0) begin
                rdata_d = entry_q[reg_addr_in[3:2]];
            end else if (reg_addr_in[11:4] == wake_offload_pkg::OFFSET_ENTRY1[11:4]
                         && reg_addr_in[1:0] == 2'h0) begin
                rdata_d = entry_q[{1'b1, reg_addr_in[3:2]}];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q            <= wake_offload_pkg::CTRL_RESET;
            resume_cfg_q      <= 2'h0;
            for (int i = 0; i < 8; i++) begin
                entry_q[i] <= wake_offload_pkg::ENTRY_RESET;
            end
            reg_rdata_out     <= 32'h00000000;
            forward_out       <= 1'b0;
            sink_out          <= 1'b0;
            solicit_reply_out <= 1'b0;
            addr_reply_out    <= 1'b0;
            wake_out          <= 1'b0;
            entry_match_out   <= 2'h0;
            advert_source_out <= 128'h0;
        end else begin
            ctrl_q            <= ctrl_d;
            resume_cfg_q      <= resume_cfg_d;
            for (int i = 0; i < 8; i++) begin
                entry_q[i] <= entry_d[i];
            end
            reg_rdata_out     <= rdata_d;
            forward_out       <= fwd_d;
            sink_out          <= sink_d;
            solicit_reply_out <= sol_rep_d;
            addr_reply_out    <= addr_rep_d;
            wake_out          <= wake_d;
            entry_match_out   <= match_d;
            advert_source_out <= adv_d;
        end
    end

    sequence s_sol_frame;
        frame_in.done && checks_ok && frame_in.kind == wake_offload_pkg::FRAME_SOL;
    endsequence

    a_sol_seen_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
        s_sol_frame |=> ctrl_q[wake_offload_pkg::BIT_SOL_SEEN])
        else $error("solicit flag not set");
    a_addr_seen_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
        frame_in.done && checks_ok && frame_in.kind == wake_offload_pkg::FRAME_ADDR
        |=> ctrl_q[wake_offload_pkg::BIT_ADDR_SEEN])
        else $error("address resolution flag not set");
    a_flag_sticky: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ctrl_q[7] && !(reg_write_in && reg_addr_in == wake_offload_pkg::OFFSET_CTRL && reg_wdata_in[7])
        |=> ctrl_q[7])
        else $error("flag dropped without clear");
    a_bypass_fcs: assert property (@(posedge clock_in) disable iff (!rstn_in)
        frame_in.done && !frame_in.fcs_ok |-> !checks_ok)
        else $error("bad FCS accepted");
    a_csum_need: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !ctrl_q[31] && frame_in.done && !frame_in.ip_csum_ok |-> !checks_ok)
        else $error("bad checksum accepted");
    a_sol_gate: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !ctrl_q[wake_offload_pkg::BIT_SOL_EN] |=> !solicit_reply_out)
        else $error("reply while disabled");
    a_addr_gate: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !ctrl_q[wake_offload_pkg::BIT_ADDR_EN] |=> !addr_reply_out)
        else $error("reply while disabled");
    a_resume_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
        resume_done_in && resume_cfg_q[1] |=> ctrl_q[1:0] == 2'h0 || $past(reg_write_in))
        else $error("enables not cleared on resume");
    a_fwd_sink: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !(forward_out && sink_out))
        else $error("forward and sink together");

    // Named steps shared by the properties below
    sequence s_syn_frame;
        frame_in.done && checks_ok && frame_in.kind == wake_offload_pkg::FRAME_SYN;
    endsequence

    sequence s_sol_any;
        frame_in.done && frame_in.kind == wake_offload_pkg::FRAME_SOL;
    endsequence

    sequence s_sol_armed;
        ctrl_q[wake_offload_pkg::BIT_SOL_EN] && frame_in.da_qualifies && frame_in.is_v6 && checks_ok;
    endsequence

    // Connection-request flags
    a_v6_seen_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
        s_syn_frame ##0 frame_in.is_v6 |=> ctrl_q[wake_offload_pkg::BIT_V6_SEEN])
        else $error("v6 connect flag not set");

    a_v4_seen_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
        s_syn_frame ##0 !frame_in.is_v6 |=> ctrl_q[wake_offload_pkg::BIT_V4_SEEN])
        else $error("v4 connect flag not set");

    // A frame in the resume cycle may set a flag again, so only quiet cycles are judged
    a_resume_flags: assert property (@(posedge clock_in) disable iff (!rstn_in)
        resume_done_in && resume_cfg_q[wake_offload_pkg::BIT_RES_FLAGS] && !frame_in.done
        |=> ctrl_q[5:4] == 2'h0)
        else $error("connect flags not cleared on resume");

    // Fate of offloaded frames
    a_addr_fwd: assert property (@(posedge clock_in) disable iff (!rstn_in)
        addr_reply_out |-> forward_out == $past(ctrl_q[wake_offload_pkg::BIT_FWD_ADDR]))
        else $error("address resolution fate wrong");

    a_sol_fwd: assert property (@(posedge clock_in) disable iff (!rstn_in)
        solicit_reply_out |-> forward_out == $past(ctrl_q[wake_offload_pkg::BIT_FWD_SOL]))
        else $error("solicitation fate wrong");

    a_reply_fate: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (solicit_reply_out || addr_reply_out) |-> forward_out != sink_out)
        else $error("offloaded frame neither passed nor sunk");

    a_adv_target: assert property (@(posedge clock_in) disable iff (!rstn_in)
        solicit_reply_out && !$past(ctrl_q[wake_offload_pkg::BIT_ADV_SEL])
        |-> advert_source_out == $past(frame_in.target_addr))
        else $error("advert source not the target address");

    a_addr_reply_en: assert property (@(posedge clock_in) disable iff (!rstn_in)
        addr_reply_out |-> $past(ctrl_q[wake_offload_pkg::BIT_ADDR_EN]))
        else $error("address reply without enable");

    // Wake gating
    a_v6_wake: assert property (@(posedge clock_in) disable iff (!rstn_in)
        wake_out && $past(frame_in.is_v6) |-> $past(ctrl_q[wake_offload_pkg::BIT_V6_WAKE]))
        else $error("v6 wake without enable");

    a_v4_wake: assert property (@(posedge clock_in) disable iff (!rstn_in)
        wake_out && !$past(frame_in.is_v6) |-> $past(ctrl_q[wake_offload_pkg::BIT_V4_WAKE]))
        else $error("v4 wake without enable");

    // Destination entry matching, checksum bypass and entry word writes
    a_reply_match: assert property (@(posedge clock_in) disable iff (!rstn_in)
        solicit_reply_out |-> entry_match_out != 2'h0)
        else $error("solicit reply without entry match");

    a_match_gate: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !ctrl_q[wake_offload_pkg::BIT_SOL_EN] |=> entry_match_out == 2'h0)
        else $error("entry match while offload disabled");

    a_full_compare: assert property (@(posedge clock_in) disable iff (!rstn_in)
        s_sol_any ##0 !solicited && ent0 != frame_in.ip6_dest |=> !entry_match_out[0])
        else $error("entry matched a different address");

    a_solicited_cmp: assert property (@(posedge clock_in) disable iff (!rstn_in)
        s_sol_any ##0 s_sol_armed ##0 solicited && ent0[127:104] == frame_in.ip6_dest[23:0]
        |=> entry_match_out[0])
        else $error("solicited-node match missed");

    a_bypass_fcs_only: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ctrl_q[wake_offload_pkg::BIT_BYPASS] && frame_in.done && frame_in.fcs_ok |-> checks_ok)
        else $error("bypass still needs checksums");

    a_entry_word0: assert property (@(posedge clock_in) disable iff (!rstn_in)
        reg_write_in && reg_addr_in == wake_offload_pkg::OFFSET_ENTRY0 |=> entry_q[0] == $past(reg_wdata_in))
        else $error("entry word write lost");

endmodule

/* verification/remote_station.sv */
`timescale 1ns/1ns
module remote_station (
    // Clock
    input  wire logic                        clock_in,
    // Request from the bench
    input  wire logic                        send_in,
    input  wire wake_offload_pkg::rx_frame_s frm_in,
    // Frame towards the block
    output wake_offload_pkg::rx_frame_s      frame_out
);
    // Between frames every field but done flips each cycle, so a stale value cannot pass for a fresh one
    always @(posedge clock_in) begin
        if (send_in) begin
            frame_out      <= frm_in;
            frame_out.done <= 1'b1;
        end else begin
            frame_out      <= ~frame_out;
            frame_out.done <= 1'b0;
        end
    end
    initial frame_out = '0;
endmodule

/* verification/test_wake_offload_ctrl.sv */
`timescale 1ns/1ns
module test_wake_offload_ctrl;
    localparam logic [11:0]  CTRL = wake_offload_pkg::OFFSET_CTRL;
    localparam logic [11:0]  RCFG = wake_offload_pkg::OFFSET_RESUME_CFG;
    localparam logic [127:0] EA   = 128'h20010db8000000000000000000a1b2c3;
    localparam logic [127:0] EB   = 128'hfe800000000000000211223344556677;
    localparam logic [127:0] TGT  = 128'h20010db80000000000000000deadbeef;
    logic                        clock_in;
    logic                        rstn_in = 1'b0;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic                        send = 1'b0;
    logic                        resume = 1'b0;
    logic [11:0]                 addr = 12'h0;
    logic [31:0]                 wdata = 32'h0;
    logic [31:0]                 rdata;
    logic                        fwd, snk, srep, arep, wake;
    logic [1:0]                  em;
    logic [127:0]                adv;
    wake_offload_pkg::rx_frame_s frm = '0;
    wake_offload_pkg::rx_frame_s frame;
    int                          fail_count = 0;
    int                          n_compared = 0;
    int                          cycles = 0;

    remote_station peer (.clock_in(clock_in), .send_in(send), .frm_in(frm), .frame_out(frame));
    wake_offload_ctrl uut (
        .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .frame_in(frame),
        .resume_done_in(resume), .forward_out(fwd), .sink_out(snk), .solicit_reply_out(srep),
        .addr_reply_out(arep), .wake_out(wake), .entry_match_out(em), .advert_source_out(adv));

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A whole run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk("read data", {96'h0, exp}, {96'h0, rdata});
    endtask

    // Returns just after the edge on which the block took the frame, while its decisions stand
    task automatic send_frame(input wake_offload_pkg::rx_frame_s f);
        @(posedge clock_in);
        send <= 1'b1;
        frm <= f;
        @(posedge clock_in);
        send <= 1'b0;
        @(posedge clock_in);
        #1;
    endtask

    task automatic dec_chk(input logic [6:0] e);
        chk("decision", {121'h0, e}, {121'h0, fwd, snk, srep, arep, wake, em});
    endtask

    task automatic pulse_resume;
        @(posedge clock_in);
        resume <= 1'b1;
        @(posedge clock_in);
        resume <= 1'b0;
    endtask

    function automatic wake_offload_pkg::rx_frame_s mk(input wake_offload_pkg::frame_kind_e k, input logic v6,
                                                        input logic [2:0] ok, input logic [127:0] dst);
        wake_offload_pkg::rx_frame_s f;
        f = '0;
        f.kind = k;
        f.is_v6 = v6;
        {f.fcs_ok, f.ip_csum_ok, f.l4_csum_ok} = ok;
        f.for_us = 1'b1;
        f.da_qualifies = 1'b1;
        f.ip6_dest = dst;
        f.target_addr = TGT;
        return f;
    endfunction

    task automatic t_regs;
        rd_chk(CTRL, 32'h0);
        rd_chk(RCFG, 32'h0);
        rd_chk(wake_offload_pkg::OFFSET_ENTRY1 + 12'hc, 32'h0);
        reg_wr(12'h7fc, 32'hffffffff);
        rd_chk(12'h7fc, 32'h0);
        reg_wr(CTRL, 32'hffffffff);
        rd_chk(CTRL, 32'h8000070f);
        reg_wr(CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            reg_wr(wake_offload_pkg::OFFSET_ENTRY0 + 12'(i * 4), EA[32 * i +: 32]);
            reg_wr(wake_offload_pkg::OFFSET_ENTRY1 + 12'(i * 4), EB[32 * i +: 32]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(wake_offload_pkg::OFFSET_ENTRY0 + 12'(i * 4), EA[32 * i +: 32]);
            rd_chk(wake_offload_pkg::OFFSET_ENTRY1 + 12'(i * 4), EB[32 * i +: 32]);
        end
    endtask

    task automatic t_flags;
        wake_offload_pkg::frame_kind_e kk [4];
        kk = '{wake_offload_pkg::FRAME_SOL, wake_offload_pkg::FRAME_ADDR,
               wake_offload_pkg::FRAME_SYN, wake_offload_pkg::FRAME_SYN};
        for (int i = 0; i < 4; i++) begin
            send_frame(mk(kk[i], i != 3, 3'b011, EA));
            rd_chk(CTRL, 32'h0);
            send_frame(mk(kk[i], i != 3, 3'b111, EA));
            rd_chk(CTRL, 32'h80 >> i);
            reg_wr(CTRL, 32'h0);
            rd_chk(CTRL, 32'h80 >> i);
            reg_wr(CTRL, 32'h80 >> i);
            rd_chk(CTRL, 32'h0);
        end
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b101, EA));
        rd_chk(CTRL, 32'h0);
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b110, EA));
        rd_chk(CTRL, 32'h0);
        reg_wr(CTRL, 32'h80000000);
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b100, EA));
        rd_chk(CTRL, 32'h80000010);
        reg_wr(CTRL, 32'h10);
    endtask

    task automatic t_addr_offload;
        reg_wr(CTRL, 32'h4);
        send_frame(mk(wake_offload_pkg::FRAME_ADDR, 1'b0, 3'b111, EA));
        dec_chk(7'b0101000);
        reg_wr(CTRL, 32'h404);
        send_frame(mk(wake_offload_pkg::FRAME_ADDR, 1'b0, 3'b111, EA));
        dec_chk(7'b1001000);
        reg_wr(CTRL, 32'h400);
        send_frame(mk(wake_offload_pkg::FRAME_ADDR, 1'b0, 3'b111, EA));
        chk("addr reply", 128'h0, {127'h0, arep});
        reg_wr(CTRL, 32'h40);
    endtask

    task automatic t_solicit;
        wake_offload_pkg::rx_frame_s f;
        reg_wr(CTRL, 32'h8);
        send_frame(mk(wake_offload_pkg::FRAME_SOL, 1'b1, 3'b111, EA));
        dec_chk(7'b0110001);
        chk("advert source", TGT, adv);
        reg_wr(CTRL, 32'h308);
        send_frame(mk(wake_offload_pkg::FRAME_SOL, 1'b1, 3'b111, {wake_offload_pkg::SOLICITED_PREFIX, EB[127:104]}));
        dec_chk(7'b1010010);
        chk("advert source", EB, adv);
        send_frame(mk(wake_offload_pkg::FRAME_SOL, 1'b1, 3'b111, EA ^ 128'h1));
        chk("entry match", 128'h0, {126'h0, em});
        f = mk(wake_offload_pkg::FRAME_SOL, 1'b1, 3'b111, EA);
        f.da_qualifies = 1'b0;
        send_frame(f);
        chk("entry match", 128'h0, {126'h0, em});
        reg_wr(CTRL, 32'h300);
        send_frame(mk(wake_offload_pkg::FRAME_SOL, 1'b1, 3'b111, EA));
        chk("solicit reply", 128'h0, {125'h0, srep, em});
        reg_wr(CTRL, 32'h80);
    endtask

    task automatic t_wake_resume;
        reg_wr(CTRL, 32'h1);
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b111, EA));
        chk("wake", 128'h1, {127'h0, wake});
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b1, 3'b111, EA));
        chk("wake", 128'h0, {127'h0, wake});
        reg_wr(CTRL, 32'h2);
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b1, 3'b111, EA));
        chk("wake", 128'h1, {127'h0, wake});
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b111, EA));
        chk("wake", 128'h0, {127'h0, wake});
        reg_wr(CTRL, 32'h3);
        send_frame(mk(wake_offload_pkg::FRAME_ADDR, 1'b0, 3'b111, EA));
        reg_wr(RCFG, 32'h1);
        pulse_resume();
        rd_chk(CTRL, 32'h43);
        reg_wr(RCFG, 32'h2);
        send_frame(mk(wake_offload_pkg::FRAME_SYN, 1'b0, 3'b111, EA));
        pulse_resume();
        rd_chk(CTRL, 32'h50);
    endtask

    initial begin
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_regs();
        t_flags();
        t_addr_offload();
        t_solicit();
        t_wake_resume();
        print_verdict();
    end
endmodule
